// ### sbcfg_pkg.sv
// constants of the serial bus configuration block
// assumes an 8-bit special-function-register bus with byte address and strobes
// How it works
// - enable bit makes interface watch SCL/SDA
// - inhibit bit masks slave interrupts, master kept
// - busy set by transfer, cleared by STOP/free
// - bit four selects extended SDA setup/hold
// - timeout enable reloads timer while SCL high
// - split timer mode reloads only high byte
// - free after both high over ten ticks
// - two-bit field picks timer overflow source
// - pending master START issued after free timeout
// - inhibit from next START, addresses NACKed
// - selected source overflow sets minimum SCL low/high
package sbcfg_pkg;
  localparam logic [7:0] CFG_ADDR      = 8'hc1;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam int         BIT_ENABLE    = 7;
  localparam int         BIT_INHIBIT   = 6;
  localparam int         BIT_BUSY      = 5;
  localparam int         BIT_SDA_EXTENDED_TIMING   = 4;
  localparam int         BIT_TOE       = 3;
  localparam int         BIT_FTE       = 2;
  localparam logic [7:0] WRITE_MASK    = 8'hdf;
  localparam logic [3:0] FREE_TICKS    = 4'ha;
  localparam logic [1:0] SETUP_NORMAL  = 2'h1;
  localparam logic [3:0] HOLD_NORMAL   = 4'h3;
  localparam logic [3:0] SETUP_EXT     = 4'hb;
  localparam logic [3:0] HOLD_EXT      = 4'hc;
  localparam int         TIMEOUT_MS    = 25;
endpackage : sbcfg_pkg

// ### sbcfg_sync.sv
// two-flop synchroniser for a bank of pins
// assumes inputs asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module sbcfg_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // pins in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sbcfg_sync_s;
  sbcfg_sync_s st;
  sbcfg_sync_s next_st;
  // reset to idle-high lines so no false START at release
  always_comb begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '{meta: '1, stable: '1};
    end else begin
      st <= next_st;
    end
  end
  assign sync_out = st.stable;
endmodule : sbcfg_sync
`default_nettype wire

// ### sbcfg_top.sv
// serial bus configuration register and its timing/timeout side logic
// assumes byte SFR bus on core_clk; scl/sda pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module sbcfg_top (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // timer overflow sources and timer mode
  input  wire logic       t0_ovf,
  input  wire logic       t1_ovf,
  input  wire logic       t2h_ovf,
  input  wire logic       t2l_ovf,
  input  wire logic       t3_split,
  // from the transfer engine
  input  wire logic       start_pending,
  input  wire logic       slave_irq_req,
  input  wire logic       master_irq_req,
  input  wire logic       addr_rx,
  // to the engine and timers
  output logic            interface_enable,
  output logic            slave_irq,
  output logic            master_irq,
  output logic            addr_nack,
  output logic            bus_busy,
  output logic            bus_free,
  output logic            start_go,
  output logic            bit_tick,
  output logic      [3:0] sda_setup_clks,
  output logic      [3:0] sda_hold_clks,
  output logic            t3_reload_high,
  output logic            t3_reload_low
);
  typedef enum logic [2:0] {
    SBCFG_IDLE = 3'b001,
    SBCFG_BUSY = 3'b010,
    SBCFG_FREEWAIT = 3'b100
  } sbcfg_state_e;

  typedef struct packed {
    logic [7:0]   cfg;
    sbcfg_state_e state;
    logic [3:0]   free_cnt;
    logic         scl_q;
    logic         sda_q;
    logic         inh_live;
    logic [7:0]   rdata;
    logic         slave_irq;
    logic         master_irq;
    logic         addr_nack;
    logic         bus_free;
    logic         start_go;
    logic         tick;
    logic [3:0]   setup;
    logic [3:0]   hold;
    logic         rl_high;
    logic         rl_low;
    logic         busy;
  } sbcfg_top_s;

  sbcfg_top_s st;
  sbcfg_top_s next_st;
  logic [1:0] pins;
  logic       scl;
  logic       sda;
  logic       src_ovf;
  logic       start_c;
  logic       stop_c;
  logic       free_hit;

  sbcfg_sync #(.W(2)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins)
  );
  assign scl = pins[1];
  assign sda = pins[0];

  always_comb begin
    next_st = st;
    case (st.cfg[1:0])
      2'h0:    src_ovf = t0_ovf;
      2'h1:    src_ovf = t1_ovf;
      2'h2:    src_ovf = t2h_ovf;
      default: src_ovf = t2l_ovf;
    endcase
    // START/STOP watched only while enabled; free_hit and the free counter ignore the enable bit
    start_c = st.cfg[sbcfg_pkg::BIT_ENABLE] && scl && st.scl_q && st.sda_q && !sda;
    stop_c  = st.cfg[sbcfg_pkg::BIT_ENABLE] && scl && st.scl_q && !st.sda_q && sda;
    free_hit = st.cfg[sbcfg_pkg::BIT_FTE] && scl && sda && src_ovf
               && (st.free_cnt == sbcfg_pkg::FREE_TICKS);
    next_st.scl_q = scl;
    next_st.sda_q = sda;
    if (sfr_wr && sfr_addr == sbcfg_pkg::CFG_ADDR) begin
      next_st.cfg = sfr_wdata & sbcfg_pkg::WRITE_MASK;
    end
    // inhibit sampled at START so current transfer completes
    if (start_c) begin
      next_st.inh_live = st.cfg[sbcfg_pkg::BIT_INHIBIT];
    end
    // free counter: restarts whenever either line drops
    if (!(scl && sda) || !st.cfg[sbcfg_pkg::BIT_FTE]) begin
      next_st.free_cnt = 4'h0;
    end else if (src_ovf && st.free_cnt != sbcfg_pkg::FREE_TICKS) begin
      next_st.free_cnt = st.free_cnt + 4'h1;
    end
    next_st.start_go = 1'b0;
    next_st.bus_free = 1'b0;
    case (st.state)
      SBCFG_IDLE: begin
        if (start_c) begin
          next_st.state = SBCFG_BUSY;
        end
      end
      SBCFG_BUSY: begin
        if (stop_c) begin
          next_st.state = SBCFG_IDLE;
        end else if (scl && sda) begin
          next_st.state = SBCFG_FREEWAIT;
        end
      end
      SBCFG_FREEWAIT: begin
        if (stop_c) begin
          next_st.state = SBCFG_IDLE;
        end else if (free_hit) begin
          next_st.state    = SBCFG_IDLE;
          next_st.bus_free = 1'b1;
          next_st.start_go = start_pending;
        end else if (!(scl && sda)) begin
          next_st.state = SBCFG_BUSY;
        end
      end
      default: next_st.state = SBCFG_IDLE;
    endcase
    if (!st.cfg[sbcfg_pkg::BIT_ENABLE]) begin
      next_st.state = SBCFG_IDLE;
    end
    // own flop so the busy pin carries no decode glitches
    next_st.busy = (next_st.state != SBCFG_IDLE);
    next_st.rdata = (sfr_rd && sfr_addr == sbcfg_pkg::CFG_ADDR)
                    ? {st.cfg[7:6], st.busy, st.cfg[4:0]} : 8'h00;
    next_st.slave_irq  = st.cfg[sbcfg_pkg::BIT_ENABLE] && slave_irq_req
                         && !st.inh_live;
    next_st.master_irq = st.cfg[sbcfg_pkg::BIT_ENABLE] && master_irq_req;
    next_st.addr_nack  = addr_rx && st.inh_live;
    next_st.tick = src_ovf;
    if (st.cfg[sbcfg_pkg::BIT_SDA_EXTENDED_TIMING]) begin
      next_st.setup = sbcfg_pkg::SETUP_EXT;
      next_st.hold  = sbcfg_pkg::HOLD_EXT;
    end else begin
      next_st.setup = {2'h0, sbcfg_pkg::SETUP_NORMAL};
      next_st.hold  = sbcfg_pkg::HOLD_NORMAL;
    end
    next_st.rl_high = st.cfg[sbcfg_pkg::BIT_TOE] && scl;
    next_st.rl_low  = st.cfg[sbcfg_pkg::BIT_TOE] && scl && !t3_split;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '{cfg: sbcfg_pkg::CFG_RESET, state: SBCFG_IDLE, free_cnt: 4'h0,
              scl_q: 1'b1, sda_q: 1'b1, setup: {2'h0, sbcfg_pkg::SETUP_NORMAL},
              hold: sbcfg_pkg::HOLD_NORMAL, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign interface_enable = st.cfg[sbcfg_pkg::BIT_ENABLE];
  assign sfr_rdata      = st.rdata;
  assign slave_irq      = st.slave_irq;
  assign master_irq     = st.master_irq;
  assign addr_nack      = st.addr_nack;
  assign bus_busy       = st.busy;
  assign bus_free       = st.bus_free;
  assign start_go       = st.start_go;
  assign bit_tick       = st.tick;
  assign sda_setup_clks = st.setup;
  assign sda_hold_clks  = st.hold;
  assign t3_reload_high = st.rl_high;
  assign t3_reload_low  = st.rl_low;

  property p_busy_write_ignored;
    @(posedge core_clk) disable iff (srst)
      (sfr_wr && sfr_addr == sbcfg_pkg::CFG_ADDR) |=> (st.cfg[5] == 1'b0);
  endproperty
  a_busy_write_ignored: assert property (p_busy_write_ignored) else $error("busy bit written");
  property p_reload_high;
    @(posedge core_clk) disable iff (srst)
      (st.cfg[3] && scl) |=> t3_reload_high;
  endproperty
  a_reload_high: assert property (p_reload_high) else $error("no reload with scl high");
  property p_split_low;
    @(posedge core_clk) disable iff (srst)
      t3_split |=> !t3_reload_low;
  endproperty
  a_split_low: assert property (p_split_low) else $error("low byte reloaded in split");
  property p_inh_mask;
    @(posedge core_clk) disable iff (srst)
      st.inh_live |=> !slave_irq;
  endproperty
  a_inh_mask: assert property (p_inh_mask) else $error("slave irq while inhibited");
  property p_stop_clears;
    @(posedge core_clk) disable iff (srst)
      (stop_c && st.state != SBCFG_IDLE) |=> !bus_busy;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("busy after stop");
  property p_free_count;
    @(posedge core_clk) disable iff (srst)
      bus_free |-> $past(st.free_cnt) == sbcfg_pkg::FREE_TICKS;
  endproperty
  a_free_count: assert property (p_free_count) else $error("free early");
  property p_start_go;
    @(posedge core_clk) disable iff (srst)
      start_go |-> bus_free;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start without free");
  property p_ext;
    @(posedge core_clk) disable iff (srst)
      st.cfg[4] |=> (sda_hold_clks == sbcfg_pkg::HOLD_EXT);
  endproperty
  a_ext: assert property (p_ext) else $error("extended hold missing");
  property p_enable;
    @(posedge core_clk) disable iff (srst)
      !st.cfg[7] |=> !bus_busy;
  endproperty
  a_enable: assert property (p_enable) else $error("busy while disabled");
endmodule : sbcfg_top
`default_nettype wire

// ### sbcfg_bus_model.sv
// far-side model: another master making START, STOP and an idle bus
// assumes pull-ups on both lines, so they idle high
`timescale 1ns/1ps
`default_nettype none
module sbcfg_bus_model (
  // bus lines as seen by the block
  output var logic scl,
  output var logic sda
);
  localparam realtime HALF = 62.5;
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // link clock stands still outside these frames
  task automatic start_cond;
    sda = 1'h0;
    #HALF scl = 1'h0;
    #HALF;
  endtask : start_cond
  task automatic stop_cond;
    sda = 1'h0;
    #HALF scl = 1'h1;
    #HALF sda = 1'h1;
    #HALF;
  endtask : stop_cond
  // sda rises while scl low: no stop, both lines simply end high
  task automatic release_bus;
    sda = 1'h1;
    #HALF scl = 1'h1;
    #HALF;
  endtask : release_bus
endmodule : sbcfg_bus_model
`default_nettype wire

// ### sbcfg_top_tb.sv
// self-checking bench of the configuration block through its byte bus
// assumes the bus model for scl/sda and overflow pulses made here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module sbcfg_top_tb;
  logic       core_clk = 1'h0;
  logic       srst = 1'h1;
  logic       sfr_wr = 1'h0;
  logic       sfr_rd = 1'h0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [3:0] ovf = 4'h0;
  logic       t3_split = 1'h0;
  logic       start_pending = 1'h0;
  logic       slave_irq_req = 1'h0;
  logic       master_irq_req = 1'h0;
  logic       addr_rx = 1'h0;
  logic       scl_in, sda_in, interface_enable, slave_irq, master_irq, addr_nack;
  logic       bus_busy, bus_free, start_go, bit_tick, t3_reload_high, t3_reload_low;
  logic [3:0] sda_setup_clks, sda_hold_clks;
  logic       tick_seen, free_seen, go_seen;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  sbcfg_top sbcfg_top_i (.core_clk, .srst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .scl_in, .sda_in, .t0_ovf(ovf[0]), .t1_ovf(ovf[1]), .t2h_ovf(ovf[2]),
    .t2l_ovf(ovf[3]), .t3_split, .start_pending, .slave_irq_req, .master_irq_req,
    .addr_rx, .interface_enable, .slave_irq, .master_irq, .addr_nack, .bus_busy,
    .bus_free, .start_go, .bit_tick, .sda_setup_clks, .sda_hold_clks,
    .t3_reload_high, .t3_reload_low);
  sbcfg_bus_model sbcfg_bus_model_i (.scl(scl_in), .sda(sda_in));
  always #2.5 core_clk = ~core_clk;
  // one-cycle pulses are caught here so checks need not hit their exact cycle
  always @(posedge core_clk) begin
    tick_seen <= tick_seen | bit_tick;
    free_seen <= free_seen | bus_free;
    go_seen   <= go_seen | start_go;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    step();
    sfr_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'h1;
    step();
    sfr_rd = 1'h0;
    `CHK(sfr_rdata, e)
  endtask : rd
  task automatic pulse(input int k);
    ovf[k] = 1'h1;
    step();
    ovf = 4'h0;
    step();
  endtask : pulse
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge core_clk);
    #1 srst = 1'h0;
    repeat (3) step();
    rd(8'hc1, 8'h00);
    `CHK({sda_setup_clks, sda_hold_clks}, 8'h13)
    wr(8'hc1, 8'hff);
    `CHK(interface_enable, 1'h1)
    rd(8'hc1, 8'hdf);
    wr(8'hc2, 8'h00);
    rd(8'hc2, 8'h00);
    rd(8'hc1, 8'hdf);
    wr(8'hc1, 8'h90);
    step();
    `CHK({sda_setup_clks, sda_hold_clks}, 8'hbc)
    for (int s = 0; s < 4; s++) begin
      wr(8'hc1, 8'h80 | 8'(s));
      for (int k = 0; k < 4; k++) begin
        tick_seen = 1'h0;
        pulse(k);
        step();
        `CHK(tick_seen, 1'(k == s))
      end
    end
    wr(8'hc1, 8'h88);
    repeat (3) step();
    `CHK({t3_reload_high, t3_reload_low}, 2'h3)
    t3_split = 1'h1;
    repeat (3) step();
    `CHK({t3_reload_high, t3_reload_low}, 2'h2)
    sbcfg_bus_model_i.start_cond();
    repeat (3) step();
    `CHK(t3_reload_high, 1'h0)
    rd(8'hc1, 8'ha8);
    sbcfg_bus_model_i.stop_cond();
    step();
    `CHK(bus_busy, 1'h0)
    // inhibit set mid-transfer only bites at the next start
    wr(8'hc1, 8'h80);
    sbcfg_bus_model_i.start_cond();
    wr(8'hc1, 8'hc0);
    {slave_irq_req, master_irq_req, addr_rx} = 3'h7;
    repeat (2) step();
    `CHK({slave_irq, master_irq, addr_nack}, 3'h6)
    {slave_irq_req, master_irq_req, addr_rx} = 3'h0;
    sbcfg_bus_model_i.stop_cond();
    sbcfg_bus_model_i.start_cond();
    step();
    {slave_irq_req, master_irq_req, addr_rx} = 3'h7;
    repeat (2) step();
    `CHK({slave_irq, master_irq, addr_nack}, 3'h3)
    {slave_irq_req, master_irq_req, addr_rx} = 3'h0;
    wr(8'hc1, 8'h84);
    sbcfg_bus_model_i.release_bus();
    start_pending = 1'h1;
    free_seen = 1'h0;
    go_seen = 1'h0;
    repeat (10) pulse(0);
    `CHK({free_seen, bus_busy}, 2'h1)
    pulse(0);
    step();
    `CHK({free_seen, go_seen, bus_busy}, 3'h6)
    start_pending = 1'h0;
    wrap_up();
  end
endmodule : sbcfg_top_tb
`undef CHK
`default_nettype wire
